// File: hw/pkt_bridge.sv
// Packet bridge: link-side level 3 source 'A' port fed from a narrow 'B' streaming slave.
// What this block does
// - One 'A' port, one 'B' port, data crosses.
// - 'A' form fixed as level 3 link source; 'B' single channel only.
// - Data flows from source port to sink.
// - Level 3 channels join same number, from zero.
// - Level 2 treated as shared unidirectional bus.
// - Transmit path stands alone, no receiver needed.
// - Port reaches FIFO via mux; fill steers handshake.
// - Packet available polled or direct per channel.
// - Width converted between narrow and wide words.
// - FIFO width, depth, thresholds are configurable.
// - Start, end and modulo stored with data.
// - Streaming 'B' port before FIFO is slave.
// - FIFO width never below protocol bus width.
// - 'B' port narrower than FIFO width allowed.
// - Single-channel to single-channel bridging form.
// - Evaluation build stops after one hour untethered.
// - On expiry 'A' port outputs go low, error goes high.
// - FIFO width is larger of both port widths.
module pkt_bridge
  import pkt_bridge_pkg::*;
#(
  parameter int                   DEPTH      = pkt_bridge_pkg::FIFO_DEPTH,
  parameter logic [4:0]           THRESHOLD  = 5'h04,
  parameter logic [1:0]           PAV_MODE   = pkt_bridge_pkg::pav_polled,
  parameter logic                 EVAL_BUILD = 1'b0,
  parameter longint               EVAL_LIMIT = pkt_bridge_pkg::EVAL_CYCLES
) (
  input  wire logic                                  clk_sys,
  input  wire logic                                  rstn,
  input  wire logic                                  tethered,
  input  wire pkt_bridge_pkg::b_word_s               b_word,
  input  wire logic                                  b_valid,
  output logic                                       b_ready,
  input  wire logic                                  clk_link,
  input  wire logic                                  enable_a,
  input  wire logic [pkt_bridge_pkg::ADDR_WIDTH-1:0] addr_a,
  output logic                                       write_a,
  output logic                                       start_transfer_a,
  output logic                                       sop_a,
  output logic                                       eop_a,
  output logic                                       err_a,
  output logic [pkt_bridge_pkg::MOD_WIDTH-1:0]       mod_a,
  output logic [pkt_bridge_pkg::A_WIDTH-1:0]         data_a,
  output logic [pkt_bridge_pkg::ADDR_WIDTH-1:0]      addr_out_a,
  output logic                                       ppav_a,
  output logic [pkt_bridge_pkg::CHANNELS-1:0]        dpav_a
);
  import pkt_bridge_pkg::*;

  localparam int PW = $clog2(DEPTH) + 1;
  localparam int BYTES = FIFO_WIDTH / 8;
  localparam int LANE_W = $clog2(BYTES);
  localparam logic [LANE_W-1:0] LAST_LANE = LANE_W'(BYTES - 1);

  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    for (int i = PW - 1; i >= 0; i--) begin
      b[i] = g[i] ^ ((i == PW - 1) ? 1'b0 : b[i+1]);
    end
    return b;
  endfunction

  // ----------------------------------------------------------------------
  // Reset synchronisers, one per domain
  // ----------------------------------------------------------------------
  logic [1:0] rst_sys_pipe;
  logic [1:0] rst_link_pipe;
  logic       rst_sys_n;
  logic       rst_link_n;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sys_pipe <= 2'h0;
    end else begin
      rst_sys_pipe <= {rst_sys_pipe[0], 1'b1};
    end
  end
  assign rst_sys_n = rst_sys_pipe[1];

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      rst_link_pipe <= 2'h0;
    end else begin
      rst_link_pipe <= {rst_link_pipe[0], 1'b1};
    end
  end
  assign rst_link_n = rst_link_pipe[1];

  // ----------------------------------------------------------------------
  // Narrow to wide packer on the user side
  // ----------------------------------------------------------------------
  // Bytes fill from the most significant lane so the first byte of a packet
  // leads on the wire; a short end word reports its count in mod.
  fifo_word_s        pack;
  logic [LANE_W-1:0] lane;
  logic              pack_full;
  logic              fifo_full;
  logic              b_take;

  assign b_take = b_valid && b_ready;

  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      pack      <= '0;
      lane      <= '0;
      pack_full <= 1'b0;
    end else begin
      if (pack_full && !fifo_full) begin
        pack_full <= 1'b0;
      end
      if (b_take) begin
        pack.data[(BYTES - 1 - lane) * 8 +: 8] <= b_word.data;
        if (lane == '0) begin
          pack.sop <= b_word.sop;
          pack.data[FIFO_WIDTH-9:0] <= '0;
        end
        pack.eop <= b_word.eop;
        pack.mod <= MOD_WIDTH'(lane) + MOD_WIDTH'(1);
        if (b_word.eop || lane == LAST_LANE) begin
          lane      <= '0;
          pack_full <= 1'b1;
        end else begin
          lane <= lane + LANE_W'(1);
        end
      end
    end
  end

  // Back-pressure: the packer holds one word until the FIFO takes it.
  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      b_ready <= 1'b0;
    end else begin
      b_ready <= !(pack_full || (b_take && (b_word.eop || lane == LAST_LANE))) ||
                 (pack_full && !fifo_full && !b_take);
    end
  end

  // ----------------------------------------------------------------------
  // Dual-clock packet FIFO
  // ----------------------------------------------------------------------
  fifo_word_s      mem [DEPTH];
  logic [PW-1:0]   wr_ptr;
  logic [PW-1:0]   wr_gray;
  logic [PW-1:0]   rd_ptr;
  logic [PW-1:0]   rd_gray;
  logic [PW-1:0]   rd_gray_s1;
  logic [PW-1:0]   rd_gray_s2;
  logic [PW-1:0]   wr_gray_s1;
  logic [PW-1:0]   wr_gray_s2;
  logic [PW-1:0]   eop_cnt_w;
  logic [PW-1:0]   eop_gray;
  logic [PW-1:0]   eop_gray_s1;
  logic [PW-1:0]   eop_gray_s2;
  logic [PW-1:0]   eop_cnt_r;
  logic            fifo_push;

  assign fifo_push = pack_full && !fifo_full;
  assign fifo_full = (wr_ptr - gray2bin(rd_gray_s2)) >= PW'(DEPTH);

  always_ff @(posedge clk_sys) begin
    if (fifo_push) begin
      mem[wr_ptr[PW-2:0]] <= pack;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      wr_ptr     <= '0;
      wr_gray    <= '0;
      eop_cnt_w  <= '0;
      eop_gray   <= '0;
      rd_gray_s1 <= '0;
      rd_gray_s2 <= '0;
    end else begin
      rd_gray_s1 <= rd_gray;
      rd_gray_s2 <= rd_gray_s1;
      if (fifo_push) begin
        wr_ptr  <= wr_ptr + PW'(1);
        wr_gray <= bin2gray(wr_ptr + PW'(1));
        if (pack.eop) begin
          eop_cnt_w <= eop_cnt_w + PW'(1);
          eop_gray  <= bin2gray(eop_cnt_w + PW'(1));
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link-side source port (transmit only)
  // ----------------------------------------------------------------------
  logic [PW-1:0] level;
  logic          pkt_ready;
  logic          in_burst;
  logic          expired;
  logic          expired_s1;
  logic          expired_s2;
  logic          tethered_s1;
  logic          tethered_s2;
  logic          enable_s1;
  logic          enable_s2;
  logic [ADDR_WIDTH-1:0] addr_s1;
  logic [ADDR_WIDTH-1:0] addr_s2;
  fifo_word_s    head;

  assign head      = mem[rd_ptr[PW-2:0]];
  assign level     = gray2bin(wr_gray_s2) - rd_ptr;
  // A packet is offered once a whole packet or the threshold is queued.
  assign pkt_ready = (level >= PW'(THRESHOLD)) ||
                     (gray2bin(eop_gray_s2) != eop_cnt_r);

  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      wr_gray_s1  <= '0;
      wr_gray_s2  <= '0;
      eop_gray_s1 <= '0;
      eop_gray_s2 <= '0;
      expired_s1  <= 1'b0;
      expired_s2  <= 1'b0;
      tethered_s1 <= 1'b0;
      tethered_s2 <= 1'b0;
      enable_s1   <= 1'b0;
      enable_s2   <= 1'b0;
      addr_s1     <= '0;
      addr_s2     <= '0;
    end else begin
      wr_gray_s1  <= wr_gray;
      wr_gray_s2  <= wr_gray_s1;
      eop_gray_s1 <= eop_gray;
      eop_gray_s2 <= eop_gray_s1;
      expired_s1  <= expired;
      expired_s2  <= expired_s1;
      tethered_s1 <= tethered;
      tethered_s2 <= tethered_s1;
      enable_s1   <= enable_a;
      enable_s2   <= enable_s1;
      addr_s1     <= addr_a;
      addr_s2     <= addr_s1;
    end
  end

  // Only channel 0 is wired to this single 'B' port; other channels stay idle.
  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      ppav_a <= 1'b0;
      dpav_a <= '0;
    end else if (expired_s2) begin
      ppav_a <= 1'b0;
      dpav_a <= '0;
    end else begin
      ppav_a <= (PAV_MODE == pav_polled) && (addr_s2 == '0) && pkt_ready;
      dpav_a <= (PAV_MODE == pav_direct) ? CHANNELS'(pkt_ready) : '0;
    end
  end

  always_ff @(posedge clk_link or negedge rst_link_n) begin
    if (!rst_link_n) begin
      rd_ptr           <= '0;
      rd_gray          <= '0;
      eop_cnt_r        <= '0;
      in_burst         <= 1'b0;
      write_a          <= 1'b0;
      start_transfer_a <= 1'b0;
      sop_a            <= 1'b0;
      eop_a            <= 1'b0;
      err_a            <= 1'b0;
      mod_a            <= '0;
      data_a           <= '0;
      addr_out_a       <= '0;
    end else if (expired_s2) begin
      write_a          <= 1'b0;
      start_transfer_a <= 1'b0;
      sop_a            <= 1'b0;
      eop_a            <= 1'b0;
      err_a            <= 1'b1;
      mod_a            <= '0;
      data_a           <= '0;
      addr_out_a       <= '0;
    end else begin
      start_transfer_a <= 1'b0;
      write_a          <= 1'b0;
      sop_a            <= 1'b0;
      eop_a            <= 1'b0;
      // The partner's enable gates each word; fill status starts a burst.
      if (enable_s2 && (in_burst || pkt_ready) && level != '0) begin
        if (!in_burst) begin
          start_transfer_a <= 1'b1;
          addr_out_a       <= '0;
        end
        in_burst <= !head.eop;
        write_a  <= 1'b1;
        sop_a    <= head.sop;
        eop_a    <= head.eop;
        mod_a    <= head.mod;
        data_a   <= A_WIDTH'(head.data);
        rd_ptr   <= rd_ptr + PW'(1);
        rd_gray  <= bin2gray(rd_ptr + PW'(1));
        if (head.eop) begin
          eop_cnt_r <= eop_cnt_r + PW'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Evaluation timer
  // ----------------------------------------------------------------------
  // The timer runs on the system clock; the tether input is pin-level so it
  // is synchronised before use here as well.
  logic [63:0] eval_count;
  logic        teth_sys_s1;
  logic        teth_sys_s2;

  always_ff @(posedge clk_sys or negedge rst_sys_n) begin
    if (!rst_sys_n) begin
      eval_count  <= '0;
      expired     <= 1'b0;
      teth_sys_s1 <= 1'b0;
      teth_sys_s2 <= 1'b0;
    end else begin
      teth_sys_s1 <= tethered;
      teth_sys_s2 <= teth_sys_s1;
      if (EVAL_BUILD && !teth_sys_s2 && !expired) begin
        eval_count <= eval_count + 64'h1;
        if (eval_count >= 64'(EVAL_LIMIT) - 64'h1) begin
          expired <= 1'b1;
        end
      end
    end
  end

endmodule // pkt_bridge

// File: hw/pkt_bridge_pkg.sv
// Shared constants, types and timing figures for the packet bridge.
package pkt_bridge_pkg;

  // ----------------------------------------------------------------------
  // Widths and word layout
  // ----------------------------------------------------------------------
  localparam int A_WIDTH     = 32;
  localparam int B_WIDTH     = 8;
  localparam int FIFO_WIDTH  = (A_WIDTH > B_WIDTH) ? A_WIDTH : B_WIDTH;
  localparam int MOD_WIDTH   = $clog2(FIFO_WIDTH / 8) + 1;
  localparam int ADDR_WIDTH  = 2;
  localparam int CHANNELS    = 4;
  localparam int FIFO_DEPTH  = 16;

  // ----------------------------------------------------------------------
  // Evaluation limit
  // ----------------------------------------------------------------------
  localparam longint EVAL_LIMIT_S = 3600;
  localparam longint CLK_HZ       = 125000000;
  localparam longint EVAL_CYCLES  = EVAL_LIMIT_S * CLK_HZ;

  typedef enum logic [1:0] {
    form_single_channel_phy_form = 2'h0,
    form_multi_channel_phy_form  = 2'h1
  } channel_form_e;

  typedef enum logic [1:0] {
    level_link_2 = 2'h0,
    level_link_3 = 2'h1,
    level_phy_2  = 2'h2,
    level_phy_3  = 2'h3
  } port_kind_e;

  typedef enum logic [1:0] {
    pav_polled = 2'h0,
    pav_direct = 2'h1
  } pav_mode_e;

  // One packet word with its flags; flags always travel with the data.
  typedef struct packed {
    logic                  sop;
    logic                  eop;
    logic [MOD_WIDTH-1:0]  mod;
    logic [FIFO_WIDTH-1:0] data;
  } fifo_word_s;

  typedef struct packed {
    logic                 sop;
    logic                 eop;
    logic [B_WIDTH-1:0]   data;
  } b_word_s;

endpackage : pkt_bridge_pkg

// File: test/link_partner.sv
// Behavioural far-side packet receiver on the link port.
module link_partner
  import pkt_bridge_pkg::*;
(
  input wire logic                                  clk_link,
  input wire logic                                  rstn,
  input wire logic                                  slow,
  input wire logic                                  hold,
  input wire logic                                  write_a,
  input wire logic                                  sop_a,
  input wire logic                                  eop_a,
  input wire logic [pkt_bridge_pkg::MOD_WIDTH-1:0]  mod_a,
  input wire logic [pkt_bridge_pkg::A_WIDTH-1:0]    data_a,
  output logic                                      enable_a,
  output logic [pkt_bridge_pkg::ADDR_WIDTH-1:0]     addr_a
);
  timeunit 1ns;
  timeprecision 100ps;
  fifo_word_s got[$];
  int         seed = 65;

  // Slow mode grants about one cycle in four, so the bridge has to stall.
  // The polled address restarts from channel 0 whenever reset is applied.
  always @(negedge clk_link) begin
    enable_a <= rstn && !hold && (!slow || ($random(seed) & 3) == 0);
    addr_a   <= rstn ? addr_a + ADDR_WIDTH'(1) : '0;
  end
  always @(posedge clk_link) begin
    if (rstn && write_a === 1'b1) begin
      got.push_back('{sop_a, eop_a, mod_a, data_a});
    end
  end
endmodule // link_partner

// File: test/pkt_bridge_properties.sv
// Port-level concurrent checks for the packet bridge.
module pkt_bridge_properties
  import pkt_bridge_pkg::*;
(
  input wire logic                                  clk_sys,
  input wire logic                                  rstn,
  input wire logic                                  b_ready,
  input wire logic                                  clk_link,
  input wire logic                                  enable_a,
  input wire logic                                  write_a,
  input wire logic                                  start_transfer_a,
  input wire logic                                  sop_a,
  input wire logic                                  eop_a,
  input wire logic                                  err_a,
  input wire logic [pkt_bridge_pkg::MOD_WIDTH-1:0]  mod_a,
  input wire logic [pkt_bridge_pkg::A_WIDTH-1:0]    data_a,
  input wire logic [pkt_bridge_pkg::ADDR_WIDTH-1:0] addr_out_a,
  input wire logic                                  ppav_a,
  input wire logic [pkt_bridge_pkg::CHANNELS-1:0]   dpav_a
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------------
  AST_SOP_WITH_WRITE: assert property (@(posedge clk_link) disable iff (!rstn)
    sop_a |-> write_a) else $error("start flag without a word");
  AST_EOP_MOD_RANGE: assert property (@(posedge clk_link) disable iff (!rstn)
    eop_a |-> write_a && mod_a inside {[1:4]}) else $error("bad end word");
  AST_START_WITH_WRITE: assert property (@(posedge clk_link) disable iff (!rstn)
    start_transfer_a |-> write_a) else $error("burst start without a word");
  AST_CHANNEL_ZERO: assert property (@(posedge clk_link) disable iff (!rstn)
    addr_out_a == '0) else $error("channel address not zero");
  AST_IDLE_NO_WRITE: assert property (@(posedge clk_link) disable iff (!rstn)
    (!enable_a) [*6] |=> !write_a) else $error("word sent while enable low");
  AST_ERR_STAYS: assert property (@(posedge clk_link) disable iff (!rstn)
    err_a |=> err_a) else $error("error output fell after expiry");
  AST_ERR_QUIET: assert property (@(posedge clk_link) disable iff (!rstn)
    err_a && $past(err_a, 2) |-> !(write_a | start_transfer_a | sop_a | eop_a | ppav_a)
    && data_a == '0 && dpav_a == '0) else $error("outputs active after expiry");
  // ----------------------------------------------------------------------
  // User side
  // ----------------------------------------------------------------------
  AST_READY_AFTER_SYNC: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(rstn) |-> !b_ready [*2]) else $error("ready before reset sync");
endmodule // pkt_bridge_properties

bind pkt_bridge pkt_bridge_properties pkt_bridge_properties_inst (.clk_sys, .rstn, .b_ready,
  .clk_link, .enable_a, .write_a, .start_transfer_a, .sop_a, .eop_a, .err_a, .mod_a,
  .data_a, .addr_out_a, .ppav_a, .dpav_a);

// File: test/testbench.sv
// Self-checking bench for the packet bridge.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import pkt_bridge_pkg::*;
  `define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin mismatches++; \
    $display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
  logic clk_sys = 0, clk_link = 0, rstn = 0, tethered = 1, b_valid = 0, slow = 0, hold = 0;
  b_word_s b_word = '0;
  logic write_a, start_transfer_a, sop_a, eop_a, err_a, b_ready, enable_a, ppav_a, ppv;
  logic [MOD_WIDTH-1:0]  mod_a;
  logic [A_WIDTH-1:0]    data_a;
  logic [ADDR_WIDTH-1:0] addr_out_a, addr_a;
  logic [CHANNELS-1:0]   dpav_a;
  int mismatches = 0, n_tests = 0, seed = 65, n_starts = 0, n_pkts = 0;
  int lens[] = '{1, 4, 5, 7, 8};
  fifo_word_s exp_q[$];

  always #4 clk_sys = ~clk_sys;
  always #3 clk_link = ~clk_link;

  // Every packet must open exactly one burst on the link.
  always @(posedge clk_link) begin
    if (start_transfer_a === 1'b1) n_starts++;
  end

  pkt_bridge #(.EVAL_BUILD(1'b1), .EVAL_LIMIT(1000)) pkt_bridge_inst (.clk_sys, .rstn,
    .tethered, .b_word, .b_valid, .b_ready, .clk_link, .enable_a, .addr_a, .write_a,
    .start_transfer_a, .sop_a, .eop_a, .err_a, .mod_a, .data_a, .addr_out_a, .ppav_a, .dpav_a);
  link_partner link_partner_inst (.clk_link, .rstn, .slow, .hold, .write_a, .sop_a, .eop_a,
    .mod_a, .data_a, .enable_a, .addr_a);

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic send_pkt(input int len, input bit gaps);
    logic [7:0] b[$];
    fifo_word_s w;
    n_pkts++;
    for (int i = 0; i < len; i++) b.push_back(8'($random(seed)));
    for (int i = 0; i < len; i += 4) begin
      w = '0;
      w.sop = (i == 0);
      w.eop = (i + 4 >= len);
      w.mod = MOD_WIDTH'(w.eop ? len - i : 4);
      for (int k = 0; k < 4 && i + k < len; k++) w.data[31-8*k -: 8] = b[i+k];
      exp_q.push_back(w);
    end
    foreach (b[i]) begin
      @(negedge clk_sys);
      if (gaps && $random(seed) % 2) begin
        b_valid = 0;
        @(negedge clk_sys);
      end
      b_valid = 1;
      b_word = '{sop: (i == 0), eop: (i == len - 1), data: b[i]};
      for (int t = 0; t < 6000 && b_ready !== 1'b1; t++) @(negedge clk_sys);
      `CHK("b_ready", 1'b1, b_ready)
      @(posedge clk_sys);
    end
    @(negedge clk_sys);
    b_valid = 0;
  endtask

  task automatic drain(input string nm);
    fifo_word_s e, g;
    for (int t = 0; t < 8000 && link_partner_inst.got.size() < exp_q.size(); t++)
      @(negedge clk_link);
    `CHK("word count", exp_q.size(), link_partner_inst.got.size())
    `CHK("bursts", n_pkts, n_starts)
    while (exp_q.size() > 0 && link_partner_inst.got.size() > 0) begin
      e = exp_q.pop_front();
      g = link_partner_inst.got.pop_front();
      g.data &= 32'hffffffff << (32 - 8 * e.mod);
      `CHK(nm, e, g)
    end
    exp_q.delete();
    link_partner_inst.got.delete();
    n_pkts = 0;
    n_starts = 0;
    $display("test %s done", nm);
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) rstn = 1;
    repeat (4) @(negedge clk_sys);
    foreach (lens[i]) send_pkt(lens[i], 0);
    drain("corner");
    @(negedge clk_sys) slow = 1;
    repeat (10) send_pkt(1 + $unsigned($random(seed)) % 24, 1);
    drain("random");
    // A stopped partner must back the full buffer up onto the user side.
    @(negedge clk_sys) hold = 1;
    fork
      send_pkt(80, 0);
    join_none
    repeat (1500) @(negedge clk_sys);
    `CHK("b_ready full", 1'b0, b_ready)
    ppv = 1'b0;
    repeat (16) @(negedge clk_link) ppv |= ppav_a;
    `CHK("ppav_a queued", 1'b1, ppv)
    @(negedge clk_sys) hold = 0;
    wait fork;
    drain("full");
    // A packet waits behind a stopped partner, so expiry has words to hold back.
    @(negedge clk_sys) hold = 1;
    send_pkt(8, 0);
    repeat (24) @(negedge clk_link);
    `CHK("err tethered", 1'b0, err_a)
    @(negedge clk_sys) tethered = 0;
    for (int t = 0; t < 3000 && err_a !== 1'b1; t++) @(negedge clk_link);
    @(negedge clk_sys) hold = 0;
    repeat (40) @(negedge clk_link);
    `CHK("err_a", 1'b1, err_a)
    `CHK("words after expiry", 0, link_partner_inst.got.size())
    `CHK("outputs", '0, {write_a, start_transfer_a, sop_a, eop_a, data_a, ppav_a, dpav_a})
    $display("test expiry done");
    print_verdict();
  end

  initial begin
    #700000;
    mismatches++;
    $display("[ERR] watchdog expected finish seen hang");
    print_verdict();
  end
endmodule // testbench
